// [rtl/irc_pkg.sv]
// What this block does
// - Enable bit starts counter on count clock.
// - First compare after enable uses low width.
// - Low match: irq, clear counter, select high.
// - High match: irq, clear, select low, repeat.
// - Every compare match inverts carrier level.
// - Carrier stays default until first match.
// - Carrier period is N plus M plus two.
// - High phase lasts M plus one clocks.
// - Companion irq synchronised to count clock.
// - Gating event copies buffer into active bit.
// - Active bit one gates carrier onto pin.
// - Pin output starts at carrier rising edge.
// - Clearing active never shortens a high pulse.
// - Inactive and no high phase: pin low.
// - High width write while running: effective after three count clocks.
// - Pin per remote enable and buffer table.
// - Copy on second clock after gating event.
package irc_pkg;
   localparam logic [7:0]  IRC_ADDR_CTRL    = 8'h00;
   localparam logic [7:0]  IRC_ADDR_LOW     = 8'h04;
   localparam logic [7:0]  IRC_ADDR_HIGH    = 8'h08;
   localparam logic [7:0]  IRC_ADDR_CARRIER = 8'h0c;
   localparam logic [7:0]  IRC_ADDR_STATUS  = 8'h10;
   localparam int          IRC_CTRL_RUN     = 0;
   localparam int          IRC_CTRL_CKS_LSB = 4;
   localparam int          IRC_CAR_BUF      = 0;
   localparam int          IRC_CAR_ACT      = 1;
   localparam int          IRC_CAR_RMT      = 2;
   localparam int          IRC_ST_CARRIER   = 8;
   localparam int          IRC_ST_PIN       = 9;
   localparam int          IRC_ST_SELHIGH   = 10;
   localparam logic [7:0]  IRC_CMP_RST      = 8'h01;
   localparam int          IRC_HIGH_LOAD_CLKS = 3;
   localparam int          IRC_XFER_CLKS    = 2;
   localparam logic [1:0]  IRC_HTRANS_NONSEQ = 2'h2;
   localparam logic [2:0]  IRC_HSIZE_WORD   = 3'h2;

   typedef struct packed {
      logic        run;
      logic [2:0]  cks;
      logic [7:0]  low_cmp;
      logic [7:0]  high_cmp;
      logic        high_wr;
      logic        buf_bit;
      logic        rmt_en;
   } irc_cfg_t;

   typedef struct packed {
      logic [7:0]  count;
      logic        carrier;
      logic        sel_high;
      logic        active;
      logic        pin;
   } irc_stat_t;

   typedef enum logic [2:0] {
      IRC_IDLE = 3'b001,
      IRC_LOW  = 3'b010,
      IRC_HIGH = 3'b100
   } irc_state_t;
endpackage

// [rtl/irc_prescaler.sv]
`timescale 1ns/1ps
module irc_prescaler
   import irc_pkg::*;
#(
   parameter int SEL_W = 3
)(
   input  wire logic             clk_sys_i,  // System clock.
   input  wire logic             nrst_i,     // Asynchronous reset, active low.
   input  wire logic             run_i,      // Counting enabled.
   input  wire logic [SEL_W-1:0] sel_i,      // Divide by two to the power sel.
   output logic                  tick_o      // One-cycle count clock pulse.
);
   logic [(1<<SEL_W)-1:0] div_r;
   logic [(1<<SEL_W)-1:0] mask;

   assign mask   = ((1<<SEL_W)'(1) << sel_i) - (1<<SEL_W)'(1);
   assign tick_o = run_i && ((div_r & mask) == '0);

   // Restarting from zero on every enable keeps the first tick one clock after start.
   always_ff @(posedge clk_sys_i or negedge nrst_i)
   begin
      if (!nrst_i)
         div_r <= '0;
      else if (!run_i)
         div_r <= '0;
      else
         div_r <= div_r + (1<<SEL_W)'(1);
   end
endmodule

// [rtl/irc_top.sv]
// Chosen here: the register offsets and register access over AHB-Lite.
`timescale 1ns/1ps
module irc_top
   import irc_pkg::*;
#(
   parameter int CNT_W = 8
)(
   input  wire logic        clk_sys_i,             // System clock, 40 MHz.
   input  wire logic        nrst_i,                // Asynchronous reset, active low.
   input  wire logic        hsel,                  // AHB slave select.
   input  wire logic [31:0] haddr,                 // AHB address.
   input  wire logic [1:0]  htrans,                // AHB transfer type.
   input  wire logic        hwrite,                // AHB write.
   input  wire logic [2:0]  hsize,                 // AHB size.
   input  wire logic [31:0] hwdata,                // AHB write data.
   input  wire logic        hready,                // AHB bus ready.
   output logic [31:0]      hrdata,                // AHB read data.
   output logic             hreadyout,             // AHB slave ready.
   output logic             hresp,                 // AHB response, always OKAY.
   input  wire logic        companion_match_irq_i, // Companion counter interrupt.
   output logic             compare_match_irq_o,   // Pulse on every compare match.
   output logic             sync_gating_event_o,   // Pulse on synchronised gating event.
   output logic             timer_output_pin_o     // Carrier output pin.
);
   irc_cfg_t          cfg_r;
   irc_stat_t         st;
   irc_state_t        state_r;
   logic [CNT_W-1:0]  count_r;
   logic [CNT_W-1:0]  high_eff_r;
   logic [1:0]        high_wait_r;
   logic              high_pend_r;
   logic              carrier_r;
   logic              active_r;
   logic              pin_r;
   logic              tick;
   logic              match;
   logic [CNT_W-1:0]  cmp_val;
   logic              comp_s1_r;
   logic              comp_s2_r;
   logic              comp_s3_r;
   logic              comp_hold_r;
   logic              gate_r;
   logic              gate_nxt;
   logic              comp_rise;
   logic [1:0]        xfer_cnt_r;
   logic              aph_wr_r;
   logic              aph_rd_r;
   logic [7:0]        aph_addr_r;
   logic [31:0]       rdata_r;
   logic              a_valid;

   function automatic logic [31:0] rd_mux(input logic [7:0] a, input irc_cfg_t c,
                                          input irc_stat_t s);
      logic [31:0] v;
      v = 32'h0;
      case (a)
         IRC_ADDR_CTRL:
         begin
            v[IRC_CTRL_RUN] = c.run;
            v[IRC_CTRL_CKS_LSB +: 3] = c.cks;
         end
         IRC_ADDR_LOW:     v[7:0] = c.low_cmp;
         IRC_ADDR_HIGH:    v[7:0] = c.high_cmp;
         IRC_ADDR_CARRIER:
         begin
            v[IRC_CAR_BUF] = c.buf_bit;
            v[IRC_CAR_ACT] = s.active;
            v[IRC_CAR_RMT] = c.rmt_en;
         end
         IRC_ADDR_STATUS:
         begin
            v[7:0] = s.count;
            v[IRC_ST_CARRIER] = s.carrier;
            v[IRC_ST_PIN]     = s.pin;
            v[IRC_ST_SELHIGH] = s.sel_high;
         end
         default:          v = 32'h0;
      endcase
      return v;
   endfunction

   irc_prescaler #(.SEL_W(3)) u_presc (
      .clk_sys_i (clk_sys_i),
      .nrst_i    (nrst_i),
      .run_i     (cfg_r.run),
      .sel_i     (cfg_r.cks),
      .tick_o    (tick)
   );

   // Bus slave: zero wait states, every access answered OKAY.
   assign a_valid   = hsel && hready && htrans[1];
   assign hreadyout = 1'b1;
   assign hresp     = 1'b0;
   assign hrdata    = rdata_r;

   always_ff @(posedge clk_sys_i or negedge nrst_i)
   begin
      if (!nrst_i)
      begin
         aph_wr_r   <= 1'b0;
         aph_rd_r   <= 1'b0;
         aph_addr_r <= 8'h00;
      end
      else
      begin
         aph_wr_r   <= a_valid && hwrite;
         aph_rd_r   <= a_valid && !hwrite;
         aph_addr_r <= haddr[7:0];
      end
   end

   // Read data is captured in the address phase, so it stands through the data phase.
   always_ff @(posedge clk_sys_i or negedge nrst_i)
   begin
      if (!nrst_i)
         rdata_r <= 32'h0;
      else if (a_valid && !hwrite)
         rdata_r <= rd_mux(haddr[7:0], cfg_r, st);
   end

   always_ff @(posedge clk_sys_i or negedge nrst_i)
   begin
      if (!nrst_i)
      begin
         cfg_r.run      <= 1'b0;
         cfg_r.cks      <= 3'h0;
         cfg_r.low_cmp  <= IRC_CMP_RST;
         cfg_r.high_cmp <= IRC_CMP_RST;
         cfg_r.high_wr  <= 1'b0;
         cfg_r.buf_bit  <= 1'b0;
         cfg_r.rmt_en   <= 1'b0;
      end
      else
      begin
         cfg_r.high_wr <= 1'b0;
         if (aph_wr_r)
         begin
            case (aph_addr_r)
               IRC_ADDR_CTRL:
               begin
                  cfg_r.run <= hwdata[IRC_CTRL_RUN];
                  cfg_r.cks <= hwdata[IRC_CTRL_CKS_LSB +: 3];
               end
               IRC_ADDR_LOW:     cfg_r.low_cmp <= hwdata[7:0];
               IRC_ADDR_HIGH:
               begin
                  cfg_r.high_cmp <= hwdata[7:0];
                  cfg_r.high_wr  <= 1'b1;
               end
               IRC_ADDR_CARRIER:
               begin
                  cfg_r.buf_bit <= hwdata[IRC_CAR_BUF];
                  cfg_r.rmt_en  <= hwdata[IRC_CAR_RMT];
               end
               default:
               begin
               end
            endcase
         end
      end
   end

   // A high width written while running takes effect after three count clocks; written while stopped, on the next clock.
   always_ff @(posedge clk_sys_i or negedge nrst_i)
   begin
      if (!nrst_i)
      begin
         high_eff_r  <= IRC_CMP_RST;
         high_pend_r <= 1'b0;
         high_wait_r <= 2'h0;
      end
      else if (cfg_r.high_wr && !cfg_r.run)
      begin
         high_eff_r  <= cfg_r.high_cmp;
         high_pend_r <= 1'b0;
      end
      else if (cfg_r.high_wr)
      begin
         high_pend_r <= 1'b1;
         high_wait_r <= 2'h0;
      end
      else if (high_pend_r && tick)
      begin
         if (high_wait_r == 2'(IRC_HIGH_LOAD_CLKS - 1))
         begin
            high_eff_r  <= cfg_r.high_cmp;
            high_pend_r <= 1'b0;
         end
         else
            high_wait_r <= high_wait_r + 2'h1;
      end
   end

   // Idle lasts one clock after enable: the first count clock is masked, and the low
   // width is always the first value compared.
   assign cmp_val = (state_r == IRC_HIGH) ? high_eff_r : cfg_r.low_cmp;
   assign match   = tick && (state_r != IRC_IDLE) && (count_r == cmp_val);

   always_ff @(posedge clk_sys_i or negedge nrst_i)
   begin
      if (!nrst_i)
         state_r <= IRC_IDLE;
      else if (!cfg_r.run)
         state_r <= IRC_IDLE;
      else
      begin
         case (state_r)
            IRC_IDLE: state_r <= IRC_LOW;
            IRC_LOW:  if (match) state_r <= IRC_HIGH;
            IRC_HIGH: if (match) state_r <= IRC_LOW;
            default:  state_r <= IRC_IDLE;
         endcase
      end
   end

   // The match clock itself counts as the last clock of a phase, hence N+1 and M+1.
   always_ff @(posedge clk_sys_i or negedge nrst_i)
   begin
      if (!nrst_i)
         count_r <= '0;
      else if (!cfg_r.run)
         count_r <= '0;
      else if (match)
         count_r <= '0;
      else if (tick && state_r != IRC_IDLE)
         count_r <= count_r + CNT_W'(1);
   end

   always_ff @(posedge clk_sys_i or negedge nrst_i)
   begin
      if (!nrst_i)
         carrier_r <= 1'b0;
      else if (!cfg_r.run)
         carrier_r <= 1'b0;
      else if (match)
         carrier_r <= !carrier_r;
   end

   // Registered so the pulse appears on the same edge as the carrier and pin change.
   always_ff @(posedge clk_sys_i or negedge nrst_i)
   begin
      if (!nrst_i)
         compare_match_irq_o <= 1'b0;
      else
         compare_match_irq_o <= match;
   end

   // Two flip-flops retime the companion interrupt; a sticky hold catches a pulse
   // that arrives between count clocks.
   always_ff @(posedge clk_sys_i or negedge nrst_i)
   begin
      if (!nrst_i)
      begin
         comp_s1_r <= 1'b0;
         comp_s2_r <= 1'b0;
         comp_s3_r <= 1'b0;
      end
      else
      begin
         comp_s1_r <= companion_match_irq_i;
         comp_s2_r <= comp_s1_r;
         comp_s3_r <= comp_s2_r;
      end
   end

   assign comp_rise = comp_s2_r && !comp_s3_r;
   assign gate_nxt  = tick && (comp_hold_r || comp_rise);

   // A rise that meets a count clock is used at once; holding it as well would
   // raise a second gating event on the next count clock.
   always_ff @(posedge clk_sys_i or negedge nrst_i)
   begin
      if (!nrst_i)
         comp_hold_r <= 1'b0;
      else if (comp_rise && !tick)
         comp_hold_r <= 1'b1;
      else if (tick)
         comp_hold_r <= 1'b0;
   end

   always_ff @(posedge clk_sys_i or negedge nrst_i)
   begin
      if (!nrst_i)
         gate_r <= 1'b0;
      else
         gate_r <= gate_nxt;
   end

   assign sync_gating_event_o = gate_r;

   // The count starts on the count clock that raises the event, so the copy lands on
   // the second count clock after it for every prescaler setting; starting one clock
   // later would cost an extra count clock when the prescaler divides by one.
   always_ff @(posedge clk_sys_i or negedge nrst_i)
   begin
      if (!nrst_i)
      begin
         xfer_cnt_r <= 2'h0;
         active_r   <= 1'b0;
      end
      else if (gate_nxt)
         xfer_cnt_r <= 2'(IRC_XFER_CLKS);
      else if (tick && xfer_cnt_r != 2'h0)
      begin
         xfer_cnt_r <= xfer_cnt_r - 2'h1;
         if (xfer_cnt_r == 2'h1)
            active_r <= cfg_r.buf_bit;
      end
   end

   // Pin follows the carrier only from a rising edge and holds a high phase to its end.
   // Once high it takes the carrier's next level, so both fall on the same edge.
   always_ff @(posedge clk_sys_i or negedge nrst_i)
   begin
      if (!nrst_i)
         pin_r <= 1'b0;
      else if (!cfg_r.rmt_en)
         pin_r <= cfg_r.buf_bit;
      else if (!cfg_r.buf_bit && !pin_r)
         pin_r <= 1'b0;
      else if (pin_r)
         pin_r <= carrier_r ^ match;
      else if (active_r && match && !carrier_r)
         pin_r <= 1'b1;
      else
         pin_r <= 1'b0;
   end

   assign timer_output_pin_o = pin_r;

   assign st.count    = count_r;
   assign st.carrier  = carrier_r;
   assign st.sel_high = (state_r == IRC_HIGH);
   assign st.active   = active_r;
   assign st.pin      = pin_r;
endmodule

// [tb/irc_properties.sv]
`timescale 1ns/1ps
module irc_properties
   import irc_pkg::*;
#(
   parameter int CNT_W = 8
)(
   input wire logic        clk_sys_i,             // Clock.
   input wire logic        nrst_i,                // Reset, active low.
   input wire logic        hsel,                  // Select.
   input wire logic [31:0] haddr,                 // Address.
   input wire logic [1:0]  htrans,                // Transfer type.
   input wire logic        hwrite,                // Write.
   input wire logic [2:0]  hsize,                 // Size.
   input wire logic [31:0] hwdata,                // Write data.
   input wire logic        hready,                // Bus ready.
   input wire logic [31:0] hrdata,                // Read data.
   input wire logic        hreadyout,             // Slave ready.
   input wire logic        hresp,                 // Response.
   input wire logic        companion_match_irq_i, // Companion interrupt.
   input wire logic        compare_match_irq_o,   // Match pulse.
   input wire logic        sync_gating_event_o,   // Gating pulse.
   input wire logic        timer_output_pin_o     // Pin.
);
   logic       wr_q;
   logic [7:0] a_q;
   logic       run_q;
   logic       rmt_q;
   logic       buf_q;
   logic [2:0] since_q;
   // Mirrors of the bus writes; since_q masks the few cycles a write needs to land.
   always_ff @(posedge clk_sys_i or negedge nrst_i)
   begin
      if (!nrst_i)
      begin
         wr_q <= 1'b0;
         a_q <= 8'h00;
         run_q <= 1'b0;
         rmt_q <= 1'b0;
         buf_q <= 1'b0;
         since_q <= 3'h0;
      end
      else
      begin
         wr_q <= hsel && hready && htrans[1] && hwrite;
         if (hsel && hready && htrans[1])
            a_q <= haddr[7:0];
         since_q <= wr_q ? 3'h0 : (since_q == 3'h7 ? since_q : since_q + 3'h1);
         if (wr_q && a_q == IRC_ADDR_CTRL)
            run_q <= hwdata[IRC_CTRL_RUN];
         if (wr_q && a_q == IRC_ADDR_CARRIER)
            {rmt_q, buf_q} <= {hwdata[IRC_CAR_RMT], hwdata[IRC_CAR_BUF]};
      end
   end
   default clocking cb @(posedge clk_sys_i); endclocking
   default disable iff (!nrst_i);
   ready_okay_a: assert property (hreadyout && !hresp) else $error("bus answer wrong");
   irq_single_a: assert property (compare_match_irq_o |=> !compare_match_irq_o)
      else $error("match pulse too long");
   gate_single_a: assert property (sync_gating_event_o |=> !sync_gating_event_o)
      else $error("gating pulse too long");
   reset_quiet_a: assert property ($rose(nrst_i) |-> !timer_output_pin_o)
      else $error("pin high after reset");
   stopped_quiet_a: assert property (!run_q && since_q == 3'h7 |-> !compare_match_irq_o)
      else $error("match while stopped");
   level_follow_a: assert property (!rmt_q && since_q == 3'h7 |-> timer_output_pin_o == buf_q)
      else $error("pin not buffer level");
   idle_low_a: assert property (!run_q && rmt_q && since_q == 3'h7 |-> !timer_output_pin_o)
      else $error("pin high while idle");
   rise_at_match_a: assert property (run_q && rmt_q && since_q == 3'h7 && $rose(timer_output_pin_o)
      |-> compare_match_irq_o || $past(compare_match_irq_o) || $past(compare_match_irq_o, 2))
      else $error("pin rose off a match");
   fall_at_match_a: assert property (run_q && rmt_q && since_q == 3'h7 && $fell(timer_output_pin_o)
      |-> compare_match_irq_o || $past(compare_match_irq_o) || $past(compare_match_irq_o, 2))
      else $error("pin fell off a match");
   cover property (compare_match_irq_o);
   cover property (sync_gating_event_o);
   cover property (rmt_q && $fell(timer_output_pin_o));
endmodule

bind irc_top irc_properties #(.CNT_W(CNT_W)) u_props (.*);

// [tb/irc_companion.sv]
`timescale 1ns/1ps
module irc_companion (
   input  wire logic        clk_sys_i, // Clock.
   input  wire logic        nrst_i,    // Reset, active low.
   input  wire logic        run_i,     // Counting enabled.
   input  wire logic [11:0] gap_i,     // Clocks between interrupts.
   output logic             irq_o      // Match pulse.
);
   logic [11:0] cnt_r;
   // The bench keeps gap_i far above six count ticks, else gating events may merge.
   always_ff @(posedge clk_sys_i or negedge nrst_i)
   begin
      if (!nrst_i)
      begin
         cnt_r <= 12'h000;
         irq_o <= 1'b0;
      end
      else
      begin
         irq_o <= run_i && cnt_r == gap_i;
         cnt_r <= (!run_i || cnt_r == gap_i) ? 12'h000 : cnt_r + 12'h001;
      end
   end
endmodule

// [tb/tb.sv]
`timescale 1ns/1ps
module tb
   import irc_pkg::*;
;
   logic        clk_sys_i = 0, nrst_i = 0, hsel = 0, hwrite = 0, c_run = 0;
   logic [31:0] haddr = 0, hwdata = 0, rd;
   logic [1:0]  htrans = 0;
   logic [2:0]  hsize = IRC_HSIZE_WORD;
   wire  logic [31:0] hrdata;
   wire  logic  hreadyout, hresp, c_irq, irq, gev, pin;
   int          n_fail = 0, checks_done = 0, k, hi;
   int          row[4][5] = '{'{1, 1, 0, 2, 4}, '{3, 1, 1, 4, 12}, '{2, 5, 0, 6, 9},
                              '{255, 1, 0, 2, 258}};
   logic [7:0]  ra[6] = '{IRC_ADDR_CTRL, IRC_ADDR_LOW, IRC_ADDR_HIGH, IRC_ADDR_CARRIER,
                          IRC_ADDR_STATUS, 8'h20};
   logic [31:0] rv[6] = '{32'h0, 32'h1, 32'h1, 32'h0, 32'h0, 32'h0};
   always #12.5 clk_sys_i = ~clk_sys_i;
   irc_top #(.CNT_W(8)) uut (.clk_sys_i(clk_sys_i), .nrst_i(nrst_i), .hsel(hsel),
      .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
      .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
      .companion_match_irq_i(c_irq), .compare_match_irq_o(irq),
      .sync_gating_event_o(gev), .timer_output_pin_o(pin));
   irc_companion u_comp (.clk_sys_i(clk_sys_i), .nrst_i(nrst_i), .run_i(c_run),
      .gap_i(12'h12c), .irq_o(c_irq));
   task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string nm);
      checks_done++;
      if (got !== exp)
      begin
         n_fail++;
         $display("BAD %s exp %h got %h", nm, exp, got);
      end
   endtask
   task automatic close_out();
      $display("checks %0d mismatches %0d", checks_done, n_fail);
      if (n_fail == 0 && checks_done > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask
   // Selector 0 pin, 1 match pulse, 2 gating pulse, else slave ready; k counts edges.
   task automatic wt(input int w, input logic v);
      k = 0;
      do
      begin
         @(posedge clk_sys_i);
         k++;
      end while ((w == 0 ? pin : w == 1 ? irq : w == 2 ? gev : hreadyout) !== v && k < 3000);
      if (k >= 3000)
      begin
         n_fail++;
         close_out();
      end
   endtask
   task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge clk_sys_i);
      hsel <= 1'b1;
      htrans <= IRC_HTRANS_NONSEQ;
      haddr <= {24'h0, a};
      hwrite <= w;
      wt(3, 1'b1);
      hsel <= 1'b0;
      htrans <= 2'h0;
      hwdata <= d;
      wt(3, 1'b1);
      rd = hrdata;
   endtask
   initial
   begin
      repeat (5) @(posedge clk_sys_i);
      nrst_i <= 1'b1;
      c_run <= 1'b1;
      bus(1, 8'h20, 32'hffffffff);
      for (int j = 0; j < 6; j++)
      begin
         bus(0, ra[j], 0);
         chk(rd, rv[j], "reset value");
      end
      $display("reset test done");
      for (int i = 0; i < 4; i++)
      begin
         bus(1, IRC_ADDR_CTRL, 0);
         bus(1, IRC_ADDR_LOW, row[i][0]);
         bus(1, IRC_ADDR_HIGH, row[i][1]);
         bus(1, IRC_ADDR_CARRIER, 32'h5);
         bus(1, IRC_ADDR_CTRL, (row[i][2] << 4) | 1);
         wt(1, 1'b1);
         wt(1, 1'b0);
         wt(1, 1'b1);
         chk(k + 1, (row[i][1] + 1) << row[i][2], "first gap");
         wt(0, 1'b1);
         wt(0, 1'b0);
         hi = k;
         chk(hi, row[i][3], "high width");
         wt(0, 1'b1);
         chk(hi + k, row[i][4], "period");
         $display("row %0d done", i);
      end
      bus(1, IRC_ADDR_CTRL, 0);
      bus(1, IRC_ADDR_LOW, 3);
      bus(1, IRC_ADDR_HIGH, 5);
      bus(1, IRC_ADDR_CTRL, 1);
      wt(0, 1'b1);
      bus(1, IRC_ADDR_HIGH, 2);
      repeat (3) wt(0, 1'b1);
      wt(0, 1'b0);
      chk(k, 3, "new high width");
      $display("high rewrite test done");
      bus(1, IRC_ADDR_CARRIER, 32'h4);
      wt(2, 1'b1);
      repeat (20) @(posedge clk_sys_i);
      chk(pin, 1'b0, "pin gated off");
      bus(0, IRC_ADDR_CARRIER, 0);
      chk(rd, 32'h4, "active cleared");
      bus(1, IRC_ADDR_CARRIER, 32'h5);
      wt(2, 1'b1);
      bus(0, IRC_ADDR_CARRIER, 0);
      chk(rd, 32'h7, "active set");
      $display("gating test done");
      bus(1, IRC_ADDR_CTRL, 0);
      bus(1, IRC_ADDR_CARRIER, 32'h1);
      repeat (4) @(posedge clk_sys_i);
      chk(pin, 1'b1, "buffer level high");
      bus(1, IRC_ADDR_CARRIER, 32'h0);
      repeat (4) @(posedge clk_sys_i);
      chk(pin, 1'b0, "buffer level low");
      $display("level test done");
      bus(1, IRC_ADDR_CARRIER, 32'h5);
      bus(1, IRC_ADDR_HIGH, 2);
      bus(1, IRC_ADDR_CTRL, 1);
      wt(0, 1'b1);
      nrst_i <= 1'b0;
      repeat (2) @(posedge clk_sys_i);
      nrst_i <= 1'b1;
      @(posedge clk_sys_i);
      chk(pin, 1'b0, "pin after reset");
      bus(0, IRC_ADDR_LOW, 0);
      chk(rd, 32'h1, "low after reset");
      $display("mid reset test done");
      close_out();
   end
endmodule
